// ---- bench/qac_host_model.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// Serial host that stands on the far side of the register bank.
// ----------------------------------------
module qac_host_model
(
  input wire logic clk_i,
  input wire logic io_i,
  input wire logic out_i,
  output logic sclk_o,
  output logic sel_n_o,
  output logic sd_o,
  output logic sd_oe_o
);
  logic four_wire = 1'b0;
  initial
  begin
    sclk_o = 1'b0;
    sel_n_o = 1'b1;
    sd_o = 1'b0;
    sd_oe_o = 1'b0;
  end
  // Six system clocks per phase leaves margin over the synchroniser delay.
  task automatic half();
    repeat (6) @(negedge clk_i);
  endtask
  task automatic xfer(input logic rd, input logic [6:0] addr, input logic [15:0] wd,
                      output logic [15:0] rdat);
    logic [23:0] frame;
    frame = {rd, addr, wd};
    rdat = 16'h0000;
    sel_n_o = 1'b0;
    sd_oe_o = 1'b1;
    for (int i = 23; i >= 0; i--)
    begin
      if (rd && i < 16)
        sd_oe_o = 1'b0;
      sd_o = frame[i];
      half();
      sclk_o = 1'b1;
      if (rd && i < 16)
        rdat[i] = four_wire ? out_i : io_i;
      half();
      sclk_o = 1'b0;
    end
    sd_oe_o = 1'b0;
    half();
    sel_n_o = 1'b1;
    repeat (8) @(negedge clk_i);
  endtask
endmodule

// ---- bench/testbench.sv ----
`timescale 1ns/1ps
module testbench;
  import qac_pkg::*;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic en_pin = 1'b1;
  logic [13:0] mag [4] = '{14'd0, 14'd0, 14'd0, 14'd0};
  logic io_last = 1'b0;
  logic out_last = 1'b0;
  logic sclk, sel_n, h_d, h_oe, io_o, io_oe, out_o, out_oe, io_w, out_w;
  logic fmt, dec_ab, dec_cd, flt_ab, flt_cd, src_ab, src_cd, grd_ab, grd_cd, ref_cd;
  logic sync_ab, sync_cd;
  logic [2:0] rat_ab, rat_cd, ph_ab, ph_cd;
  logic [8:0] dly_ab, dly_cd;
  logic [3:0] ovr_pin, ovr_oe;
  logic [15:0] pwr;
  int mismatches = 0;
  int n_checks = 0;
  int cycles = 0;
  // An undriven line toggles so a stale level can never pass for read data.
  assign io_w = io_oe ? io_o : (h_oe ? h_d : ~io_last);
  assign out_w = out_oe ? out_o : ~out_last;
  always #20 clk_i = ~clk_i;
  always @(posedge clk_i)
  begin
    io_last <= io_w;
    out_last <= out_w;
    cycles <= cycles + 1;
    if (cycles == 60000)
    begin
      mismatches++;
      report_and_stop();
    end
  end
  qac_host_model host (.clk_i(clk_i), .io_i(io_w), .out_i(out_w), .sclk_o(sclk),
    .sel_n_o(sel_n), .sd_o(h_d), .sd_oe_o(h_oe));
  qac_reg_bank dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .serial_clk_i(sclk),
    .serial_select_n_i(sel_n), .serial_io_pin_i(io_w), .serial_io_pin_o(io_o),
    .serial_io_pin_oe_o(io_oe), .serial_out_pin_o(out_o), .serial_out_pin_oe_o(out_oe),
    .enable_pin_i(en_pin), .mag_a_i(mag[0]), .mag_b_i(mag[1]), .mag_c_i(mag[2]),
    .mag_d_i(mag[3]), .overrange_pin_o(ovr_pin), .overrange_pin_oe_o(ovr_oe),
    .offset_binary_o(fmt), .decim_enable_pair_ab_o(dec_ab), .decim_enable_pair_cd_o(dec_cd),
    .filter_type_pair_ab_o(flt_ab), .filter_type_pair_cd_o(flt_cd),
    .clock_source_pair_ab_o(src_ab), .clock_source_pair_cd_o(src_cd),
    .div_ratio_pair_ab_o(rat_ab), .div_ratio_pair_cd_o(rat_cd),
    .clock_phase_pair_ab_o(ph_ab), .clock_phase_pair_cd_o(ph_cd),
    .phase_change_guard_ab_o(grd_ab), .phase_change_guard_cd_o(grd_cd),
    .frame_ref_source_cd_o(ref_cd), .frame_ref_delay_ab_ps_o(dly_ab),
    .frame_ref_delay_cd_ps_o(dly_cd), .link_sync_buffer_en_ab_o(sync_ab),
    .link_sync_buffer_en_cd_o(sync_cd), .power_on_o(pwr));
  // ----------------------------------------
  // Shared tasks.
  // ----------------------------------------
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    logic [15:0] unused;
    host.xfer(1'b0, a, d, unused);
  endtask
  task automatic rd_chk(input logic [6:0] a, input logic [15:0] exp);
    logic [15:0] got;
    host.xfer(1'b1, a, 16'h0000, got);
    check("register read", got, exp);
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios.
  // ----------------------------------------
  logic [6:0] addr_t [10] = '{ADDR_OVR, ADDR_CLKDIV, ADDR_PINREF, ADDR_PINSLEEP,
    ADDR_SERSLEEP, ADDR_PHSW_AB, ADDR_PHSW_CD, ADDR_PREEMP_CD, ADDR_OUTCUR_CD, ADDR_PLLSEL};
  logic [15:0] rst_t [10] = '{16'haf7a, 16'h4040, 16'h000f, 16'h0000, 16'hffff,
    16'h0144, 16'h0144, RST_PREEMP, RST_OUTCUR, RST_PLLSEL};
  logic [15:0] wm_t [10] = '{WM_OVR, WM_CLKDIV, WM_PINREF, WM_ALL, WM_ALL, WM_PHSW,
    WM_PHSW, WM_PREEMP, WM_ALL, WM_PLLSEL};
  task automatic t_reset();
    for (int i = 0; i < 10; i++) rd_chk(addr_t[i], rst_t[i]);
    rd_chk(ADDR_GLOBAL, 16'h0000);
    rd_chk(7'h02, 16'h0000);
    check("reset levels", 16'({src_ab, src_cd, sync_ab, sync_cd, ovr_oe}), 16'h00f0);
    check("reset ratios", 16'({rat_ab, rat_cd}), 16'h0009);
    check("reset power", pwr, 16'hffff);
    $display("test reset done");
  endtask
  task automatic t_access();
    logic [15:0] v;
    for (int p = 0; p < 2; p++)
      for (int i = 0; i < 10; i++)
      begin
        v = p ? 16'h0000 : 16'hffff;
        wr(addr_t[i], v);
        rd_chk(addr_t[i], (rst_t[i] & ~wm_t[i]) | (v & wm_t[i]));
      end
    $display("test access done");
  endtask
  task automatic t_global();
    wr(ADDR_GLOBAL, 16'h5200);
    check("format set", 16'({fmt, dec_ab, flt_ab, dec_cd, flt_cd}), 16'h0015);
    wr(ADDR_GLOBAL, 16'h2400);
    check("decim set", 16'({fmt, dec_ab, flt_ab, dec_cd, flt_cd}), 16'h000a);
    wr(ADDR_GLOBAL, 16'h8000);
    host.four_wire = 1'b1;
    rd_chk(ADDR_GLOBAL, 16'h8000);
    rd_chk(ADDR_CLKDIV, 16'h4040);
    wr(ADDR_GLOBAL, 16'h0000);
    host.four_wire = 1'b0;
    rd_chk(ADDR_GLOBAL, 16'h0000);
    $display("test global done");
  endtask
  task automatic t_soft_reset();
    wr(ADDR_CLKDIV, 16'h0000);
    wr(ADDR_PINSLEEP, 16'h1234);
    wr(ADDR_GLOBAL, 16'h0001);
    rd_chk(ADDR_GLOBAL, 16'h0000);
    rd_chk(ADDR_CLKDIV, 16'h4040);
    rd_chk(ADDR_PINSLEEP, 16'h0000);
    $display("test soft reset done");
  endtask
  task automatic t_clock();
    wr(ADDR_PHSW_AB, 16'h0200);
    wr(ADDR_PHSW_CD, 16'h0200);
    check("guards on", 16'({grd_ab, grd_cd}), 16'h0003);
    wr(ADDR_CLKDIV, 16'h2597);
    check("sources", 16'({src_ab, src_cd, ref_cd}), 16'h0001);
    check("ratios", 16'({rat_ab, rat_cd}), 16'h0014);
    check("phases", 16'({ph_ab, ph_cd}), 16'h001d);
    wr(ADDR_CLKDIV, 16'h4777);
    check("sources back", 16'({src_ab, src_cd, ref_cd}), 16'h0006);
    check("unused ratio", 16'({rat_ab, rat_cd}), 16'h0009);
    check("phases one bit", 16'({ph_ab, ph_cd}), 16'h0009);
    wr(ADDR_PHSW_AB, 16'h0000);
    wr(ADDR_PHSW_CD, 16'h0000);
    check("guards off", 16'({grd_ab, grd_cd}), 16'h0000);
    $display("test clock done");
  endtask
  task automatic t_pinref();
    logic [8:0] ps [4] = '{9'd0, 9'd200, 9'd100, 9'd300};
    for (int c = 0; c < 4; c++)
    begin
      wr(ADDR_PINREF, 16'h0003 | 16'(c) << 10 | 16'(3 - c) << 8 | 16'(c) << 2);
      check("delay ab", 16'(dly_ab), 16'(ps[c]));
      check("delay cd", 16'(dly_cd), 16'(ps[3 - c]));
      check("sync buffers", 16'({sync_ab, sync_cd}), 16'(c));
    end
    $display("test frame reference done");
  endtask
  task automatic t_overrange();
    int first;
    int width;
    logic [2:0] others;
    logic [3:0] lens [4] = '{4'd1, 4'd2, 4'd4, 4'd8};
    wr(ADDR_PINREF, 16'h800f);
    check("pin enables", 16'(ovr_oe), 16'h0001);
    for (int l = 0; l < 5; l++)
    begin
      wr(ADDR_OVR, 16'h2842 | 16'(l % 4) * 16'h0084);
      @(negedge clk_i);
      for (int c = 0; c < 4; c++) mag[c] = (l == 4) ? 14'd8191 : 14'd8192;
      first = 0;
      width = 0;
      others = 3'b000;
      for (int k = 1; k <= 20; k++)
      begin
        @(negedge clk_i);
        for (int c = 0; c < 4; c++) mag[c] = 14'd0;
        if (ovr_pin[0] === 1'b1 && first == 0)
          first = k;
        if (ovr_pin[0] === 1'b1)
          width++;
        others |= ovr_pin[3:1];
      end
      check("flag latency", 16'(first), (l == 4) ? 16'd0 : 16'd6);
      check("flag width", 16'(width), (l == 4) ? 16'd0 : 16'(lens[l % 4]));
      check("disabled pins", 16'(others), 16'h0000);
    end
    $display("test overrange done");
  endtask
  task automatic t_sleep();
    logic [15:0] codes [4] = '{16'h0000, 16'h8000, 16'h801f, 16'haa9f};
    wr(ADDR_PINSLEEP, 16'h2000);
    wr(ADDR_SERSLEEP, 16'h801f);
    check("serial sleep", pwr, 16'ha01f);
    en_pin = 1'b0;
    repeat (4) @(negedge clk_i);
    check("pin sleep", pwr, 16'h2000);
    for (int i = 0; i < 4; i++)
    begin
      wr(ADDR_PINSLEEP, codes[i]);
      check("sleep code", pwr, codes[i]);
    end
    wr(ADDR_SERSLEEP, 16'hffff);
    en_pin = 1'b1;
    repeat (4) @(negedge clk_i);
    check("normal power", pwr, 16'hffff);
    $display("test sleep done");
  endtask
  initial
  begin
    repeat (16) @(negedge clk_i);
    rst_n_i = 1'b1;
    repeat (4) @(negedge clk_i);
    t_reset();
    t_access();
    t_soft_reset();
    t_global();
    t_clock();
    t_pinref();
    t_overrange();
    t_sleep();
    report_and_stop();
  end
endmodule

// ---- hdl/qac_ovr_detect.sv ----
`timescale 1ns/1ps
module qac_ovr_detect
  import qac_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [13:0] mag_i,
  input wire logic [2:0] level_i,
  input wire logic [1:0] len_i,
  output logic flag_o
);
  typedef struct packed {
    logic [4:0] dly;
    logic [3:0] hold;
    logic flag;
  } qac_ovr_t;

  qac_ovr_t s_r;
  qac_ovr_t s_nxt;
  logic over;

  // Threshold is full scale times level over eight, full scale being 2^14.
  assign over = ({3'b000, mag_i} >= {level_i, 14'h0000} >> 3) && (level_i != 3'd0); // R07

  always_comb
  begin
    s_nxt = s_r;
    // Five delay stages plus the flag register give six clocks of latency.
    s_nxt.dly = {s_r.dly[3:0], over}; // R06
    if (s_r.dly[4])
    begin
      s_nxt.hold = 4'd1 << len_i; // R08
    end
    else if (s_r.hold != 4'd0)
    begin
      s_nxt.hold = s_r.hold - 4'd1;
    end
    s_nxt.flag = s_r.dly[4] || (s_r.hold > 4'd1); // R06 R08
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign flag_o = s_r.flag;

  a_ovr_latency: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    over |-> ##6 flag_o) else $error("over-range flag late"); // R06
  a_ovr_minlen: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(flag_o) && len_i == 2'd2 && $stable(len_i) |-> flag_o [*4])
    else $error("over-range pulse too short"); // R08
endmodule

// ---- hdl/qac_reg_bank.sv ----
`timescale 1ns/1ps
// How it works
// R01: Soft reset bit restores defaults, self clears.
// R02: Width bit picks bidirectional or separate output.
// R03: Format bit: twos complement or offset binary.
// R04: Per-pair decimation enable bits.
// R05: Per-pair filter low-pass or high-pass.
// R06: Over-range flag six clocks after overload.
// R07: Threshold is full scale times field/8.
// R08: Pulse length field gives 1/2/4/8 clocks.
// R09: Host should clear over-range top bit.
// R10: Clock source from CD or AB divider.
// R11: Divider field: none, two, four, unused.
// R12: Phase field picks 2/4/8 phases.
// R13: Host guards phase change with switch bit.
// R14: CD frame reference from AB or CD.
// R15: Over-range pins drive only when enabled.
// R16: Frame reference delay codes 0/200/100/300 ps.
// R17: Link sync buffers follow enable bits.
// R18: Pin sleep bit keeps function powered.
// R19: Sleep bit map shared by both registers.
// R20: Serial sleep zero powers down, pin wins.
// R21: Host uses listed low-power codes.
// R22: Host keeps serial sleep bit 0 set.
// R23: Frame is 8 address then 16 data, MSB first.
// R24: First bit selects read; enable idles high between.
// R25: Fixed bits read constants, ignore writes.
// R26: Writable fields reset by both resets.
module qac_reg_bank
  import qac_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic serial_clk_i,
  input wire logic serial_select_n_i,
  input wire logic serial_io_pin_i,
  output logic serial_io_pin_o,
  output logic serial_io_pin_oe_o,
  output logic serial_out_pin_o,
  output logic serial_out_pin_oe_o,
  input wire logic enable_pin_i,
  input wire logic [13:0] mag_a_i,
  input wire logic [13:0] mag_b_i,
  input wire logic [13:0] mag_c_i,
  input wire logic [13:0] mag_d_i,
  output logic [3:0] overrange_pin_o,
  output logic [3:0] overrange_pin_oe_o,
  output logic offset_binary_o,
  output logic decim_enable_pair_ab_o,
  output logic decim_enable_pair_cd_o,
  output logic filter_type_pair_ab_o,
  output logic filter_type_pair_cd_o,
  output logic clock_source_pair_ab_o,
  output logic clock_source_pair_cd_o,
  output logic [2:0] div_ratio_pair_ab_o,
  output logic [2:0] div_ratio_pair_cd_o,
  output logic [2:0] clock_phase_pair_ab_o,
  output logic [2:0] clock_phase_pair_cd_o,
  output logic phase_change_guard_ab_o,
  output logic phase_change_guard_cd_o,
  output logic frame_ref_source_cd_o,
  output logic [8:0] frame_ref_delay_ab_ps_o,
  output logic [8:0] frame_ref_delay_cd_ps_o,
  output logic link_sync_buffer_en_ab_o,
  output logic link_sync_buffer_en_cd_o,
  output logic [15:0] power_on_o
);
  typedef enum logic [1:0] {ST_IDLE, ST_ADDR, ST_DATA, ST_DONE} qac_state_t;

  typedef struct packed {
    logic [2:0] sclk_sync;
    logic [1:0] sel_sync;
    logic [1:0] sdi_sync;
    logic [1:0] en_sync;
    qac_state_t state;
    logic [4:0] cnt;
    logic rd;
    logic [6:0] addr;
    logic [15:0] shift;
    logic drive;
    logic sdo;
    logic [15:0] r_global;
    logic [15:0] r_ovr;
    logic [15:0] r_clk;
    logic [15:0] r_pin;
    logic [15:0] r_psleep;
    logic [15:0] r_ssleep;
    logic [15:0] r_phab;
    logic [15:0] r_phcd;
    logic [15:0] r_preemp;
    logic [15:0] r_outcur;
    logic [15:0] r_pll;
  } qac_state_all_t;

  qac_state_all_t s_r;
  qac_state_all_t s_nxt;
  logic [3:0] ovr_flag;
  logic sclk_rise;
  logic sclk_fall;

  // Fixed bits keep their reset value whatever the host writes.
  function automatic logic [15:0] merge(input logic [15:0] rst, input logic [15:0] wm,
                                        input logic [15:0] d);
    merge = (d & wm) | (rst & ~wm); // R25
  endfunction

  function automatic logic [15:0] read_reg(input qac_state_all_t s, input logic [6:0] a);
    case (a)
      ADDR_GLOBAL: read_reg = s.r_global;
      ADDR_OVR: read_reg = s.r_ovr;
      ADDR_CLKDIV: read_reg = s.r_clk;
      ADDR_PINREF: read_reg = s.r_pin;
      ADDR_PINSLEEP: read_reg = s.r_psleep;
      ADDR_SERSLEEP: read_reg = s.r_ssleep;
      ADDR_PHSW_AB: read_reg = s.r_phab;
      ADDR_PHSW_CD: read_reg = s.r_phcd;
      ADDR_PREEMP_CD: read_reg = s.r_preemp;
      ADDR_OUTCUR_CD: read_reg = s.r_outcur;
      ADDR_PLLSEL: read_reg = s.r_pll;
      default: read_reg = 16'h0000;
    endcase
  endfunction

  // Divider code 11 is unused; it is treated as no division.
  function automatic logic [2:0] ratio(input logic [1:0] code);
    case (code)
      2'b01: ratio = 3'd2;
      2'b10: ratio = 3'd4;
      default: ratio = 3'd1;
    endcase // R11
  endfunction

  // Only as many phase bits as the ratio offers are meaningful.
  function automatic logic [2:0] phase(input logic [1:0] code, input logic [2:0] ph);
    case (code)
      2'b01: phase = {1'b0, ph[1:0]};
      2'b10: phase = ph;
      default: phase = {2'b00, ph[0]};
    endcase // R12
  endfunction

  function automatic logic [8:0] delay_ps(input logic [1:0] code);
    case (code)
      2'b01: delay_ps = 9'd200;
      2'b10: delay_ps = 9'd100;
      2'b11: delay_ps = 9'd300;
      default: delay_ps = 9'd0;
    endcase // R16
  endfunction

  function automatic qac_state_all_t defaults(input qac_state_all_t s);
    defaults = s;
    defaults.r_global = RST_GLOBAL;
    defaults.r_ovr = RST_OVR;
    defaults.r_clk = RST_CLKDIV;
    defaults.r_pin = RST_PINREF;
    defaults.r_psleep = RST_PINSLEEP;
    defaults.r_ssleep = RST_SERSLEEP;
    defaults.r_phab = RST_PHSW;
    defaults.r_phcd = RST_PHSW;
    defaults.r_preemp = RST_PREEMP;
    defaults.r_outcur = RST_OUTCUR;
    defaults.r_pll = RST_PLLSEL;
  endfunction

  // -----------------------------------------------------------------------
  // Serial frame engine
  // -----------------------------------------------------------------------
  assign sclk_rise = s_r.sclk_sync[1] && !s_r.sclk_sync[2];
  assign sclk_fall = !s_r.sclk_sync[1] && s_r.sclk_sync[2];

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.sclk_sync = {s_r.sclk_sync[1:0], serial_clk_i};
    s_nxt.sel_sync = {s_r.sel_sync[0], serial_select_n_i};
    s_nxt.sdi_sync = {s_r.sdi_sync[0], serial_io_pin_i};
    s_nxt.en_sync = {s_r.en_sync[0], enable_pin_i};
    if (s_r.r_global[B_SRST])
    begin
      s_nxt = defaults(s_nxt); // R01 R26
    end
    if (s_r.sel_sync[1])
    begin
      s_nxt.state = ST_IDLE; // R24
      s_nxt.drive = 1'b0;
      s_nxt.cnt = 5'd0;
    end
    else
    begin
      case (s_r.state)
        ST_IDLE:
        begin
          s_nxt.state = ST_ADDR;
          s_nxt.cnt = 5'd0;
        end
        ST_ADDR:
        begin
          if (sclk_rise)
          begin
            s_nxt.cnt = s_r.cnt + 5'd1;
            if (s_r.cnt == 5'd0)
            begin
              s_nxt.rd = s_r.sdi_sync[1]; // R24
            end
            else
            begin
              s_nxt.addr = {s_r.addr[5:0], s_r.sdi_sync[1]}; // R23
            end
            if (s_r.cnt == 5'(ADDR_BITS - 1))
            begin
              s_nxt.state = ST_DATA;
              s_nxt.shift = read_reg(s_r, {s_r.addr[5:0], s_r.sdi_sync[1]});
            end
          end
        end
        ST_DATA:
        begin
          if (s_r.rd && sclk_fall)
          begin
            // Data changes on the falling edge so the host samples it settled.
            s_nxt.drive = 1'b1;
            s_nxt.sdo = s_r.shift[15];
            s_nxt.shift = {s_r.shift[14:0], 1'b0};
          end
          if (sclk_rise)
          begin
            s_nxt.cnt = s_r.cnt + 5'd1;
            if (!s_r.rd)
            begin
              s_nxt.shift = {s_r.shift[14:0], s_r.sdi_sync[1]}; // R23
            end
            if (s_r.cnt == FRAME_BITS - 5'd1)
            begin
              s_nxt.state = ST_DONE;
            end
          end
        end
        ST_DONE:
        begin
          if (!s_r.rd && s_r.cnt == FRAME_BITS)
          begin
            s_nxt.cnt = 5'd0;
            case (s_r.addr)
              ADDR_GLOBAL: s_nxt.r_global = merge(RST_GLOBAL, WM_GLOBAL, s_r.shift);
              ADDR_OVR: s_nxt.r_ovr = merge(RST_OVR, WM_OVR, s_r.shift);
              ADDR_CLKDIV: s_nxt.r_clk = merge(RST_CLKDIV, WM_CLKDIV, s_r.shift);
              ADDR_PINREF: s_nxt.r_pin = merge(RST_PINREF, WM_PINREF, s_r.shift);
              ADDR_PINSLEEP: s_nxt.r_psleep = s_r.shift;
              ADDR_SERSLEEP: s_nxt.r_ssleep = s_r.shift;
              ADDR_PHSW_AB: s_nxt.r_phab = merge(RST_PHSW, WM_PHSW, s_r.shift);
              ADDR_PHSW_CD: s_nxt.r_phcd = merge(RST_PHSW, WM_PHSW, s_r.shift);
              ADDR_PREEMP_CD: s_nxt.r_preemp = merge(RST_PREEMP, WM_PREEMP, s_r.shift);
              ADDR_OUTCUR_CD: s_nxt.r_outcur = s_r.shift;
              ADDR_PLLSEL: s_nxt.r_pll = merge(RST_PLLSEL, WM_PLLSEL, s_r.shift);
              default: s_nxt.cnt = 5'd0;
            endcase
          end
        end
        default: s_nxt.state = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      s_r <= '0;
      s_r.sel_sync <= 2'b11;
      s_r.r_global <= RST_GLOBAL; // R26
      s_r.r_ovr <= RST_OVR;
      s_r.r_clk <= RST_CLKDIV;
      s_r.r_pin <= RST_PINREF;
      s_r.r_psleep <= RST_PINSLEEP;
      s_r.r_ssleep <= RST_SERSLEEP;
      s_r.r_phab <= RST_PHSW;
      s_r.r_phcd <= RST_PHSW;
      s_r.r_preemp <= RST_PREEMP;
      s_r.r_outcur <= RST_OUTCUR;
      s_r.r_pll <= RST_PLLSEL;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // -----------------------------------------------------------------------
  // Pins and configuration outputs
  // -----------------------------------------------------------------------
  assign serial_io_pin_o = s_r.sdo;
  assign serial_io_pin_oe_o = s_r.drive && !s_r.r_global[B_WIDTH4]; // R02
  assign serial_out_pin_o = s_r.sdo;
  assign serial_out_pin_oe_o = s_r.drive && s_r.r_global[B_WIDTH4]; // R02

  assign offset_binary_o = s_r.r_global[B_FORMAT]; // R03
  assign decim_enable_pair_ab_o = s_r.r_global[B_DEC_AB]; // R04
  assign decim_enable_pair_cd_o = s_r.r_global[B_DEC_CD]; // R04
  assign filter_type_pair_ab_o = s_r.r_global[B_FLT_AB]; // R05
  assign filter_type_pair_cd_o = s_r.r_global[B_FLT_CD]; // R05
  assign clock_source_pair_ab_o = s_r.r_clk[B_SRC_AB]; // R10
  assign clock_source_pair_cd_o = s_r.r_clk[B_SRC_CD]; // R10
  assign div_ratio_pair_ab_o = ratio(s_r.r_clk[B_RAT_AB +: 2]);
  assign div_ratio_pair_cd_o = ratio(s_r.r_clk[B_RAT_CD +: 2]);
  assign clock_phase_pair_ab_o = phase(s_r.r_clk[B_RAT_AB +: 2], s_r.r_clk[B_PH_AB +: 3]);
  assign clock_phase_pair_cd_o = phase(s_r.r_clk[B_RAT_CD +: 2], s_r.r_clk[B_PH_CD +: 3]);
  assign phase_change_guard_ab_o = s_r.r_phab[B_GUARD];
  assign phase_change_guard_cd_o = s_r.r_phcd[B_GUARD];
  assign frame_ref_source_cd_o = s_r.r_clk[B_REF_CD]; // R14
  assign frame_ref_delay_ab_ps_o = delay_ps(s_r.r_pin[B_DLY_AB +: 2]);
  assign frame_ref_delay_cd_ps_o = delay_ps(s_r.r_pin[B_DLY_CD +: 2]);
  assign link_sync_buffer_en_ab_o = s_r.r_pin[B_SYNC_AB]; // R17
  assign link_sync_buffer_en_cd_o = s_r.r_pin[B_SYNC_CD]; // R17

  // Pin-held bits win; otherwise low pin or serial zero powers the function down.
  assign power_on_o = s_r.r_psleep | (s_r.en_sync[1] ? s_r.r_ssleep : 16'h0000); // R18 R19 R20

  // -----------------------------------------------------------------------
  // Fast over-range detectors, one per channel, level and length per pair
  // -----------------------------------------------------------------------
  for (genvar ch = 0; ch < 4; ch++)
  begin : g_ovr
    qac_ovr_detect u_ovr (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .mag_i(ch == 0 ? mag_a_i : ch == 1 ? mag_b_i : ch == 2 ? mag_c_i : mag_d_i),
      .level_i(ch < 2 ? s_r.r_ovr[B_LVL_AB +: 3] : s_r.r_ovr[B_LVL_CD +: 3]),
      .len_i(ch < 2 ? s_r.r_ovr[B_LEN_AB +: 2] : s_r.r_ovr[B_LEN_CD +: 2]),
      .flag_o(ovr_flag[ch])
    );
  end

  // Pin A sits at the top enable bit.
  assign overrange_pin_oe_o = {<<{s_r.r_pin[B_OVR_PIN +: 4]}}; // R15
  assign overrange_pin_o = ovr_flag & overrange_pin_oe_o; // R15

  a_srst_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_r.r_global[B_SRST] |=> !s_r.r_global[B_SRST] && s_r.r_ovr == RST_OVR)
    else $error("soft reset did not restore"); // R01
  a_fixed_bits: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_r.r_pin[1:0] == 2'b11 && s_r.r_ovr[1] && !s_r.r_ovr[0] && s_r.r_phab[8])
    else $error("fixed bit changed"); // R25
  a_width_sel: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !(serial_io_pin_oe_o && serial_out_pin_oe_o))
    else $error("both serial outputs driven"); // R02
  a_pin_unused: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !overrange_pin_oe_o[0] |-> !overrange_pin_o[0])
    else $error("disabled pin active"); // R15
  a_sleep_prio: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (power_on_o & s_r.r_psleep) == s_r.r_psleep)
    else $error("pin-held function powered down"); // R20
  a_idle_quiet: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_r.sel_sync[1] |=> !serial_io_pin_oe_o && !serial_out_pin_oe_o)
    else $error("drive with select high"); // R24
  a_fmt_follow: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    offset_binary_o == s_r.r_global[B_FORMAT] && decim_enable_pair_ab_o == s_r.r_global[13])
    else $error("format or decimation mismatch"); // R03
  a_div_map: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_r.r_clk[5:4] == 2'b01 |-> div_ratio_pair_ab_o == 3'd2)
    else $error("divider map wrong"); // R11
endmodule

// ---- inc/qac_pkg.sv ----
package qac_pkg;
  // Register indices on the 7-bit serial address space.
  localparam logic [6:0] ADDR_GLOBAL = 7'h00;
  localparam logic [6:0] ADDR_OVR = 7'h01;
  localparam logic [6:0] ADDR_CLKDIV = 7'h03;
  localparam logic [6:0] ADDR_PINREF = 7'h04;
  localparam logic [6:0] ADDR_PINSLEEP = 7'h05;
  localparam logic [6:0] ADDR_SERSLEEP = 7'h06;
  localparam logic [6:0] ADDR_PHSW_AB = 7'h07;
  localparam logic [6:0] ADDR_PHSW_CD = 7'h08;
  localparam logic [6:0] ADDR_PREEMP_CD = 7'h68;
  localparam logic [6:0] ADDR_OUTCUR_CD = 7'h6b;
  localparam logic [6:0] ADDR_PLLSEL = 7'h6c;
  // Reset values.
  localparam logic [15:0] RST_GLOBAL = 16'h0000;
  localparam logic [15:0] RST_OVR = 16'haf7a;
  localparam logic [15:0] RST_CLKDIV = 16'h4040;
  localparam logic [15:0] RST_PINREF = 16'h000f;
  localparam logic [15:0] RST_PINSLEEP = 16'h0000;
  localparam logic [15:0] RST_SERSLEEP = 16'hffff;
  localparam logic [15:0] RST_PHSW = 16'h0144;
  localparam logic [15:0] RST_PREEMP = 16'h0000;
  localparam logic [15:0] RST_OUTCUR = 16'h0000;
  localparam logic [15:0] RST_PLLSEL = 16'h0000;
  // Writable masks; other bits are fixed and read their reset value.
  localparam logic [15:0] WM_GLOBAL = 16'hf601;
  localparam logic [15:0] WM_OVR = 16'h8ffc;
  localparam logic [15:0] WM_CLKDIV = 16'h77f7;
  localparam logic [15:0] WM_PINREF = 16'hff0c;
  localparam logic [15:0] WM_ALL = 16'hffff;
  localparam logic [15:0] WM_PHSW = 16'h0200;
  localparam logic [15:0] WM_PREEMP = 16'hfff0;
  localparam logic [15:0] WM_PLLSEL = 16'h0003;
  // Field positions.
  localparam int B_WIDTH4 = 15;
  localparam int B_FORMAT = 14;
  localparam int B_DEC_AB = 13;
  localparam int B_FLT_AB = 12;
  localparam int B_DEC_CD = 10;
  localparam int B_FLT_CD = 9;
  localparam int B_SRST = 0;
  localparam int B_LVL_AB = 9;
  localparam int B_LEN_AB = 7;
  localparam int B_LVL_CD = 4;
  localparam int B_LEN_CD = 2;
  localparam int B_SRC_CD = 14;
  localparam int B_RAT_CD = 12;
  localparam int B_PH_CD = 8;
  localparam int B_REF_CD = 7;
  localparam int B_SRC_AB = 6;
  localparam int B_RAT_AB = 4;
  localparam int B_PH_AB = 0;
  localparam int B_OVR_PIN = 12;
  localparam int B_DLY_AB = 10;
  localparam int B_DLY_CD = 8;
  localparam int B_SYNC_AB = 3;
  localparam int B_SYNC_CD = 2;
  localparam int B_GUARD = 9;
  // Serial frame: direction bit, 7 address bits, 16 data bits.
  localparam int ADDR_BITS = 8;
  localparam int DATA_BITS = 16;
  localparam logic [4:0] FRAME_BITS = 5'd24;
  // Fast over-range latency in output clocks.
  localparam logic [2:0] OVR_LATENCY = 3'd6;
  localparam logic [2:0] OVR_FULL_DIV = 3'd7;
endpackage
